// >>> hdl/ufc_consts.svh
// constants of the uart flow control block
//Behaviour
//(RL1) receive and transmit fifos hold 64 characters; receive entries add three error bits
//(RL2) after reset fifos are disabled, so both trigger levels are one character
//(RL3) all-zero programmable level register selects fifo control levels, otherwise programmable levels
//(RL4) auto cts and auto rts are enabled independently by feature bits 7:6
//(RL5) feature bit 7 enables auto cts, feature bit 6 enables auto rts
//(RL6) with auto cts, a character starts only while cts is low
//(RL7) cts dropping during a character lets it finish, then holds the next
//(RL8) remote drives cts high before the last stop bit midpoint to stop next
//(RL9) cts returning low resumes sending waiting transmit fifo characters
//(RL10) with auto cts, cts changes raise no host interrupt
//(RL11) auto rts stays active below halt level, drops once halt level reached
//(RL12) after dropping, rts reasserts once receive count falls to resume level
//(RL13) all-zero flow level register uses fifo control levels for halt and resume
//(RL14) feature bits 3:2 select which pause/resume characters are transmitted
//(RL15) feature bits 1:0 select which pause/resume characters are compared on receive
//(RL16) receive mode 11 accepts either char for tx 10/01, pair otherwise
//(RL17) resume_on_any lets any character after a pause resume transmission
//(RL18) feature bit 5 flags pause_char_b matches, stores them, cleared by ident read
//(RL19) pause stops transmit after current char, flags ident bit 4, interrupt if enabled
//(RL20) resume restarts transmit and clears the pause flag and its interrupt
//(RL21) pause characters are sent once receive count passes the halt level
//(RL22) resume characters are sent once receive count falls to resume level
//(RL23) flow characters are framed like data; short words send only low bits
//(RL24) pair matching needs the second character right after the first
`ifndef UFC_CONSTS_SVH
`define UFC_CONSTS_SVH
`define UFC_DEPTH 7'h40
`define UFC_AW 6
`define UFC_RXW 11
`define UFC_TXW 8
`define UFC_ERR 10:8
`define UFC_CHR 7:0
// register offsets
`define UFC_A_DATA 5'h00
`define UFC_A_IER 5'h01
`define UFC_A_IIR 5'h02
`define UFC_A_FCR 5'h03
`define UFC_A_LCR 5'h04
`define UFC_A_MCR 5'h05
`define UFC_A_TCR 5'h06
`define UFC_A_TLR 5'h07
`define UFC_A_EFR 5'h08
`define UFC_A_RA 5'h09
`define UFC_A_RB 5'h0a
`define UFC_A_PA 5'h0b
`define UFC_A_PB 5'h0c
`define UFC_A_TXLVL 5'h0d
`define UFC_A_RXLVL 5'h0e
`define UFC_A_STAT 5'h0f
`define UFC_A_ERR 5'h10
// reset values
`define UFC_RST_ZERO 8'h00
`define UFC_LCR_RST 8'h03
// fields
`define UFC_EFR_CTS 7
`define UFC_EFR_RTS 6
`define UFC_EFR_SPEC 5
`define UFC_EFR_TX 3:2
`define UFC_EFR_RX 1:0
`define UFC_FCR_EN 0
`define UFC_FCR_RXRST 1
`define UFC_FCR_TXRST 2
`define UFC_FCR_KEEP 8'hf9
`define UFC_FCR_RXT 7:6
`define UFC_FCR_TXT 5:4
`define UFC_MCR_RTS 1
`define UFC_MCR_ANY 5
`define UFC_IER_MS 3
`define UFC_IER_XOFF 5
`define UFC_HI 7:4
`define UFC_LO 3:0
`define UFC_LCR_WL 1:0
`define UFC_WL_MAX 2'h3
`define UFC_PAD 2'h0
// flow character modes
`define UFC_FM_NONE 2'h0
`define UFC_FM_B 2'h1
`define UFC_FM_A 2'h2
`define UFC_FM_AB 2'h3
`define UFC_FC_ONE 2'h1
`define UFC_FC_TWO 2'h2
// interrupt identity codes
`define UFC_IIR_NONE 8'h01
`define UFC_IIR_MS 8'h00
`define UFC_IIR_XOFF 8'h10
// trigger levels in characters
`define UFC_ONE 7'h01
`define UFC_LVL_ZERO 7'h00
`define UFC_RXT0 7'h08
`define UFC_RXT1 7'h10
`define UFC_RXT2 7'h38
`define UFC_RXT3 7'h3c
`define UFC_TXT0 7'h08
`define UFC_TXT1 7'h10
`define UFC_TXT2 7'h20
`define UFC_TXT3 7'h38
`endif

// >>> hdl/ufc_flow.sv
// uart fifo thresholds, hardware and software flow control
`timescale 1ns/1ps
`include "ufc_consts.svh"
module ufc_flow
  import ufc_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // register port
  input wire logic [4:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // characters from the receiver
  input wire logic rx_valid,
  input wire logic [7:0] rx_char,
  input wire logic [2:0] rx_err,
  // characters to the transmitter
  output logic tx_valid,
  output logic [7:0] tx_word,
  input wire logic tx_ready,
  // modem pins
  input wire logic cts_n,
  output logic rts_n,
  // host status
  output logic int_req_n,
  output logic rx_trig,
  output logic tx_trig
);

  logic rst_q1, rst_q, cts_m, cts_s, cts_d;
  logic [7:0] int_enable_reg, fifo_ctrl_reg, line_ctrl_reg, modem_ctrl_reg;
  logic [7:0] flow_level_reg, prog_level_reg, feature_ctrl_reg;
  logic [7:0] resume_char_a, resume_char_b, pause_char_a, pause_char_b;
  ufc_cnt_t rx_cnt, tx_cnt, rx_trig_lvl, tx_trig_lvl, halt_lvl, resume_lvl, tx_space;
  logic [`UFC_AW-1:0] rx_wp, rx_rp, tx_wp, tx_rp;
  logic [`UFC_RXW-1:0] rx_q;
  logic [`UFC_TXW-1:0] tx_q;
  logic rx_push, rx_pop, tx_push, tx_pop, rx_clr, tx_clr;
  logic [1:0] rx_mode, tx_mode, fc_cnt;
  logic either_ok, pair_mode, is_pause, is_resume, any_resume, spec_hit;
  logic half_pause, half_resume, tx_paused, xoff_flag, special_flag, modem_delta;
  logic pause_sent, fc_pause, fc_take, fc_sel_b, cts_ok, rts_active, iir_rd;
  logic ms_pend, xo_pend, rd_rhr;
  logic [7:0] fc_char, word_mask, iir_code, rd_reg, rx_err_reg;
  ufc_tx_e tx_st;

  function automatic ufc_cnt_t rx_sel(input logic [1:0] s);
    case (s)
      2'h0: rx_sel = `UFC_RXT0;
      2'h1: rx_sel = `UFC_RXT1;
      2'h2: rx_sel = `UFC_RXT2;
      default: rx_sel = `UFC_RXT3;
    endcase
  endfunction

  // next lower selectable level, used as the resume point
  function automatic ufc_cnt_t rx_low(input logic [1:0] s);
    case (s)
      2'h0: rx_low = `UFC_LVL_ZERO;
      2'h1: rx_low = `UFC_RXT0;
      2'h2: rx_low = `UFC_RXT1;
      default: rx_low = `UFC_RXT2;
    endcase
  endfunction

  function automatic ufc_cnt_t tx_sel(input logic [1:0] s);
    case (s)
      2'h0: tx_sel = `UFC_TXT0;
      2'h1: tx_sel = `UFC_TXT1;
      2'h2: tx_sel = `UFC_TXT2;
      default: tx_sel = `UFC_TXT3;
    endcase
  endfunction

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rst_q1 <= 1'b0;
      rst_q <= 1'b0;
    end
    else
    begin
      rst_q1 <= 1'b1;
      rst_q <= rst_q1;
    end
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_q);

  // cts is a pin: two flops before use, third only for change detection
  always_ff @(posedge ref_clk or negedge rst_q)
  begin
    if (!rst_q)
    begin
      cts_m <= 1'b1;
      cts_s <= 1'b1;
      cts_d <= 1'b1;
    end
    else
    begin
      cts_m <= cts_n;
      cts_s <= cts_m;
      cts_d <= cts_s;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_q)
  begin
    if (!rst_q)
    begin
      int_enable_reg <= `UFC_RST_ZERO;
      fifo_ctrl_reg <= `UFC_RST_ZERO; // see (RL2)
      line_ctrl_reg <= `UFC_LCR_RST;
      modem_ctrl_reg <= `UFC_RST_ZERO;
      flow_level_reg <= `UFC_RST_ZERO;
      prog_level_reg <= `UFC_RST_ZERO;
      feature_ctrl_reg <= `UFC_RST_ZERO;
    end
    else if (wr)
    begin
      case (addr)
        `UFC_A_IER: int_enable_reg <= wdata;
        `UFC_A_FCR: fifo_ctrl_reg <= wdata & `UFC_FCR_KEEP;
        `UFC_A_LCR: line_ctrl_reg <= wdata;
        `UFC_A_MCR: modem_ctrl_reg <= wdata;
        `UFC_A_TCR: flow_level_reg <= wdata;
        `UFC_A_TLR: prog_level_reg <= wdata;
        `UFC_A_EFR: feature_ctrl_reg <= wdata;
        default: ;
      endcase
    end
  end

  // flow characters keep their contents through reset
  always_ff @(posedge ref_clk)
  begin
    if (wr)
    begin
      case (addr)
        `UFC_A_RA: resume_char_a <= wdata;
        `UFC_A_RB: resume_char_b <= wdata;
        `UFC_A_PA: pause_char_a <= wdata;
        `UFC_A_PB: pause_char_b <= wdata;
        default: ;
      endcase
    end
  end

  always_comb
  begin
    if (!fifo_ctrl_reg[`UFC_FCR_EN])
    begin
      rx_trig_lvl = `UFC_ONE; // see (RL2)
      tx_trig_lvl = `UFC_ONE;
    end
    else if (prog_level_reg != `UFC_RST_ZERO)
    begin
      rx_trig_lvl = {1'b0, prog_level_reg[`UFC_HI], `UFC_PAD}; // see (RL3)
      tx_trig_lvl = {1'b0, prog_level_reg[`UFC_LO], `UFC_PAD};
    end
    else
    begin
      rx_trig_lvl = rx_sel(fifo_ctrl_reg[`UFC_FCR_RXT]); // see (RL3)
      tx_trig_lvl = tx_sel(fifo_ctrl_reg[`UFC_FCR_TXT]);
    end
  end

  always_comb
  begin
    if (flow_level_reg == `UFC_RST_ZERO)
    begin
      halt_lvl = rx_sel(fifo_ctrl_reg[`UFC_FCR_RXT]); // see (RL13)
      resume_lvl = rx_low(fifo_ctrl_reg[`UFC_FCR_RXT]);
    end
    else
    begin
      halt_lvl = {1'b0, flow_level_reg[`UFC_LO], `UFC_PAD}; // see (RL11)
      resume_lvl = {1'b0, flow_level_reg[`UFC_HI], `UFC_PAD}; // see (RL12)
    end
  end

  assign tx_space = `UFC_DEPTH - tx_cnt;
  assign rx_trig = rx_cnt >= rx_trig_lvl;
  assign tx_trig = tx_space >= tx_trig_lvl;

  trig_reset_a: assert property (!fifo_ctrl_reg[`UFC_FCR_EN] |-> rx_trig == (rx_cnt != `UFC_LVL_ZERO)) // see (RL2)
    else $error("disabled fifo trigger is not one character");

  // receive match decode
  assign rx_mode = feature_ctrl_reg[`UFC_EFR_RX]; // see (RL15)
  assign tx_mode = feature_ctrl_reg[`UFC_EFR_TX];
  assign either_ok = rx_mode == `UFC_FM_AB && (tx_mode == `UFC_FM_A || tx_mode == `UFC_FM_B); // see (RL16)
  assign pair_mode = rx_mode == `UFC_FM_AB && !either_ok;

  always_comb
  begin
    case (rx_mode)
      `UFC_FM_A:
      begin
        is_pause = rx_char == pause_char_a;
        is_resume = rx_char == resume_char_a;
      end
      `UFC_FM_B:
      begin
        is_pause = rx_char == pause_char_b;
        is_resume = rx_char == resume_char_b;
      end
      `UFC_FM_AB:
      begin
        if (either_ok)
        begin
          is_pause = rx_char == pause_char_a || rx_char == pause_char_b; // see (RL16)
          is_resume = rx_char == resume_char_a || rx_char == resume_char_b;
        end
        else
        begin
          is_pause = half_pause && rx_char == pause_char_b; // see (RL24)
          is_resume = half_resume && rx_char == resume_char_b;
        end
      end
      default:
      begin
        is_pause = 1'b0;
        is_resume = 1'b0;
      end
    endcase
  end

  assign any_resume = modem_ctrl_reg[`UFC_MCR_ANY] && tx_paused && !is_pause; // see (RL17)
  assign spec_hit = feature_ctrl_reg[`UFC_EFR_SPEC] && rx_char == pause_char_b; // see (RL18)

  // a first character only counts if the very next one completes the pair
  always_ff @(posedge ref_clk or negedge rst_q)
  begin
    if (!rst_q)
    begin
      half_pause <= 1'b0;
      half_resume <= 1'b0;
    end
    else if (rx_valid)
    begin
      half_pause <= pair_mode && rx_char == pause_char_a; // see (RL24)
      half_resume <= pair_mode && rx_char == resume_char_a;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_q)
  begin
    if (!rst_q)
    begin
      tx_paused <= 1'b0;
      xoff_flag <= 1'b0;
    end
    else if (rx_valid && is_pause)
    begin
      tx_paused <= 1'b1; // see (RL19)
      xoff_flag <= 1'b1;
    end
    else if (rx_valid && (is_resume || any_resume))
    begin
      tx_paused <= 1'b0; // see (RL20)
      xoff_flag <= 1'b0;
    end
  end

  pause_seen_a: assert property (rx_valid && is_pause |=> tx_paused && xoff_flag) // see (RL19)
    else $error("pause character did not halt and flag");
  resume_seen_a: assert property (rx_valid && !is_pause && (is_resume || any_resume) |=> !tx_paused && !xoff_flag) // see (RL20)
    else $error("resume character did not restart transmit");

  assign iir_rd = rd && addr == `UFC_A_IIR;

  // set wins over the ident read clear
  always_ff @(posedge ref_clk or negedge rst_q)
  begin
    if (!rst_q)
    begin
      special_flag <= 1'b0;
    end
    else if (rx_valid && spec_hit)
    begin
      special_flag <= 1'b1; // see (RL18)
    end
    else if (iir_rd)
    begin
      special_flag <= 1'b0;
    end
  end

  special_char_a: assert property (rx_valid && spec_hit && !is_pause && !tx_paused |=> special_flag && !tx_paused) // see (RL18)
    else $error("special character halted or missed");

  always_ff @(posedge ref_clk or negedge rst_q)
  begin
    if (!rst_q)
    begin
      modem_delta <= 1'b0;
    end
    else if (cts_s != cts_d && !feature_ctrl_reg[`UFC_EFR_CTS])
    begin
      modem_delta <= 1'b1; // see (RL10)
    end
    else if (iir_rd)
    begin
      modem_delta <= 1'b0;
    end
  end

  no_cts_int_a: assert property (feature_ctrl_reg[`UFC_EFR_CTS] && !modem_delta |=> !modem_delta) // see (RL10)
    else $error("cts change raised interrupt under auto cts");

  assign ms_pend = modem_delta && int_enable_reg[`UFC_IER_MS];
  assign xo_pend = (xoff_flag || special_flag) && int_enable_reg[`UFC_IER_XOFF]; // see (RL19)
  assign iir_code = ms_pend ? `UFC_IIR_MS : (xo_pend ? `UFC_IIR_XOFF : `UFC_IIR_NONE);
  assign int_req_n = !(ms_pend || xo_pend);

  // receive fifo: matched flow characters are consumed, not stored
  assign rx_push = rx_valid && !is_pause && !is_resume && rx_cnt != `UFC_DEPTH; // see (RL1)
  assign rx_pop = rd && addr == `UFC_A_DATA && rx_cnt != `UFC_LVL_ZERO;
  assign rx_clr = wr && addr == `UFC_A_FCR && wdata[`UFC_FCR_RXRST];
  assign tx_push = wr && addr == `UFC_A_DATA && tx_cnt != `UFC_DEPTH;
  assign tx_clr = wr && addr == `UFC_A_FCR && wdata[`UFC_FCR_TXRST];

  always_ff @(posedge ref_clk or negedge rst_q)
  begin
    if (!rst_q)
    begin
      rx_wp <= '0;
      rx_rp <= '0;
      rx_cnt <= `UFC_LVL_ZERO;
    end
    else if (rx_clr)
    begin
      rx_wp <= '0;
      rx_rp <= '0;
      rx_cnt <= `UFC_LVL_ZERO;
    end
    else
    begin
      rx_wp <= rx_wp + {5'h00, rx_push};
      rx_rp <= rx_rp + {5'h00, rx_pop};
      rx_cnt <= rx_cnt + {6'h00, rx_push} - {6'h00, rx_pop};
    end
  end

  always_ff @(posedge ref_clk or negedge rst_q)
  begin
    if (!rst_q)
    begin
      tx_wp <= '0;
      tx_rp <= '0;
      tx_cnt <= `UFC_LVL_ZERO;
    end
    else if (tx_clr)
    begin
      tx_wp <= '0;
      tx_rp <= '0;
      tx_cnt <= `UFC_LVL_ZERO;
    end
    else
    begin
      tx_wp <= tx_wp + {5'h00, tx_push};
      tx_rp <= tx_rp + {5'h00, tx_pop};
      tx_cnt <= tx_cnt + {6'h00, tx_push} - {6'h00, tx_pop};
    end
  end

  fifo_depth_a: assert property (rx_cnt <= `UFC_DEPTH && tx_cnt <= `UFC_DEPTH) // see (RL1)
    else $error("fifo count above depth");

  ufc_mem #(.W(`UFC_RXW)) u_rx_mem (
    .clk(ref_clk),
    .we(rx_push),
    .waddr(rx_wp),
    .wdata({rx_err, rx_char}),
    .raddr(rx_rp),
    .rdata(rx_q)
  );

  ufc_mem #(.W(`UFC_TXW)) u_tx_mem (
    .clk(ref_clk),
    .we(tx_push),
    .waddr(tx_wp),
    .wdata(wdata),
    .raddr(tx_rp),
    .rdata(tx_q)
  );

  // auto rts from receive occupancy; halt has priority if levels overlap
  always_ff @(posedge ref_clk or negedge rst_q)
  begin
    if (!rst_q)
    begin
      rts_active <= 1'b1;
    end
    else if (rx_cnt >= halt_lvl)
    begin
      rts_active <= 1'b0; // see (RL11)
    end
    else if (rx_cnt <= resume_lvl)
    begin
      rts_active <= 1'b1; // see (RL12)
    end
  end

  assign rts_n = feature_ctrl_reg[`UFC_EFR_RTS] ? !rts_active : !modem_ctrl_reg[`UFC_MCR_RTS]; // see (RL4)

  rts_halt_a: assert property (feature_ctrl_reg[`UFC_EFR_RTS] && rx_cnt >= halt_lvl |=> rts_n) // see (RL11)
    else $error("auto rts not withdrawn at halt level");
  rts_resume_a: assert property (feature_ctrl_reg[`UFC_EFR_RTS] && rx_cnt < halt_lvl && rx_cnt <= resume_lvl
    |=> rts_active) // see (RL12)
    else $error("auto rts not restored at resume level");

  // pause and resume characters queued for the transmitter
  always_ff @(posedge ref_clk or negedge rst_q)
  begin
    if (!rst_q)
    begin
      pause_sent <= 1'b0;
      fc_pause <= 1'b0;
      fc_cnt <= 2'h0;
    end
    else if (fc_take)
    begin
      fc_cnt <= fc_cnt - `UFC_FC_ONE;
    end
    else if (tx_mode != `UFC_FM_NONE && fc_cnt == 2'h0)
    begin
      if (!pause_sent && rx_cnt > halt_lvl)
      begin
        pause_sent <= 1'b1; // see (RL21)
        fc_pause <= 1'b1;
        fc_cnt <= tx_mode == `UFC_FM_AB ? `UFC_FC_TWO : `UFC_FC_ONE; // see (RL14)
      end
      else if (pause_sent && rx_cnt <= resume_lvl)
      begin
        pause_sent <= 1'b0; // see (RL22)
        fc_pause <= 1'b0;
        fc_cnt <= tx_mode == `UFC_FM_AB ? `UFC_FC_TWO : `UFC_FC_ONE;
      end
    end
  end

  // in the pair mode the a character goes first
  assign fc_sel_b = tx_mode == `UFC_FM_B || (tx_mode == `UFC_FM_AB && fc_cnt == `UFC_FC_ONE); // see (RL14)
  assign fc_char = fc_pause ? (fc_sel_b ? pause_char_b : pause_char_a) : (fc_sel_b ? resume_char_b : resume_char_a);
  assign word_mask = 8'hff >> (`UFC_WL_MAX - line_ctrl_reg[`UFC_LCR_WL]); // see (RL23)

  // cts is checked before each start; a character already handed over completes
  assign cts_ok = !feature_ctrl_reg[`UFC_EFR_CTS] || !cts_s; // see (RL5) see (RL6) see (RL8) see (RL9)
  assign fc_take = tx_st == UFC_IDLE && cts_ok && fc_cnt != 2'h0;
  assign tx_pop = tx_st == UFC_LOAD;
  assign tx_valid = tx_st == UFC_SEND && cts_ok; // see (RL6) see (RL7)

  always_ff @(posedge ref_clk or negedge rst_q)
  begin
    if (!rst_q)
    begin
      tx_st <= UFC_IDLE;
      tx_word <= `UFC_RST_ZERO;
    end
    else
    begin
      case (tx_st)
        UFC_IDLE:
        begin
          if (fc_take)
          begin
            tx_word <= fc_char & word_mask; // see (RL23)
            tx_st <= UFC_SEND;
          end
          else if (cts_ok && !tx_paused && tx_cnt != `UFC_LVL_ZERO)
          begin
            tx_st <= UFC_LOAD; // see (RL9) see (RL19)
          end
        end
        UFC_LOAD:
        begin
          tx_word <= tx_q & word_mask;
          tx_st <= UFC_SEND;
        end
        UFC_SEND:
        begin
          if (tx_valid && tx_ready)
          begin
            tx_st <= UFC_IDLE;
          end
        end
        default: tx_st <= UFC_IDLE;
      endcase
    end
  end

  sequence cts_blocked_s;
    feature_ctrl_reg[`UFC_EFR_CTS] && cts_s && tx_st == UFC_IDLE;
  endsequence

  sequence send_held_s;
    tx_st == UFC_SEND && !tx_valid;
  endsequence

  cts_hold_a: assert property (cts_blocked_s |=> tx_st == UFC_IDLE) // see (RL6)
    else $error("transmit started while cts inactive");
  cts_send_a: assert property (tx_st == UFC_SEND && feature_ctrl_reg[`UFC_EFR_CTS] && cts_s |-> send_held_s) // see (RL7)
    else $error("word offered while cts inactive");
  pause_hold_a: assert property (tx_paused && tx_st == UFC_IDLE && fc_cnt == 2'h0 |=> tx_st == UFC_IDLE) // see (RL19)
    else $error("paused transmitter fetched a character");
  word_mask_a: assert property (tx_valid |-> (tx_word & ~word_mask) == `UFC_RST_ZERO) // see (RL23)
    else $error("bits above word length sent");

  // register read answer, one cycle after the strobe
  always_ff @(posedge ref_clk or negedge rst_q)
  begin
    if (!rst_q)
    begin
      rd_rhr <= 1'b0;
      rd_reg <= `UFC_RST_ZERO;
    end
    else
    begin
      rd_rhr <= rd && addr == `UFC_A_DATA;
      if (rd)
      begin
        case (addr)
          `UFC_A_IER: rd_reg <= int_enable_reg;
          `UFC_A_IIR: rd_reg <= iir_code;
          `UFC_A_FCR: rd_reg <= fifo_ctrl_reg;
          `UFC_A_LCR: rd_reg <= line_ctrl_reg;
          `UFC_A_MCR: rd_reg <= modem_ctrl_reg;
          `UFC_A_TCR: rd_reg <= flow_level_reg;
          `UFC_A_TLR: rd_reg <= prog_level_reg;
          `UFC_A_EFR: rd_reg <= feature_ctrl_reg;
          `UFC_A_RA: rd_reg <= resume_char_a;
          `UFC_A_RB: rd_reg <= resume_char_b;
          `UFC_A_PA: rd_reg <= pause_char_a;
          `UFC_A_PB: rd_reg <= pause_char_b;
          `UFC_A_TXLVL: rd_reg <= {1'b0, tx_space};
          `UFC_A_RXLVL: rd_reg <= {1'b0, rx_cnt};
          `UFC_A_STAT: rd_reg <= {3'h0, modem_delta, pause_sent, !cts_s, !rts_n, tx_paused};
          `UFC_A_ERR: rd_reg <= rx_err_reg;
          default: rd_reg <= `UFC_RST_ZERO;
        endcase
      end
    end
  end

  // error bits of the character most recently read
  always_ff @(posedge ref_clk or negedge rst_q)
  begin
    if (!rst_q)
    begin
      rx_err_reg <= `UFC_RST_ZERO;
    end
    else if (rd_rhr)
    begin
      rx_err_reg <= {5'h00, rx_q[`UFC_ERR]}; // see (RL1)
    end
  end

  assign rdata = rd_rhr ? rx_q[`UFC_CHR] : rd_reg;

endmodule

// >>> hdl/ufc_mem.sv
// fifo storage with registered read data
`timescale 1ns/1ps
`include "ufc_consts.svh"
module ufc_mem
  import ufc_pkg::*;
#(
  parameter int W = `UFC_TXW
)
(
  // clock
  input wire logic clk,
  // write port
  input wire logic we,
  input wire logic [`UFC_AW-1:0] waddr,
  input wire logic [W-1:0] wdata,
  // read port
  input wire logic [`UFC_AW-1:0] raddr,
  output logic [W-1:0] rdata
);

  logic [W-1:0] mem [0:`UFC_DEPTH-1];

  always_ff @(posedge clk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk)
  begin
    rdata <= mem[raddr];
  end

endmodule

// >>> hdl/ufc_pkg.sv
// types of the uart flow control block
package ufc_pkg;
  typedef enum logic [1:0] {UFC_IDLE = 2'h0, UFC_LOAD = 2'h1, UFC_SEND = 2'h3} ufc_tx_e;
  typedef logic [6:0] ufc_cnt_t;
endpackage

// >>> testbench/ufc_flow_test.sv
// self-checking bench of the uart flow control block
`timescale 1ns/1ps
`include "ufc_consts.svh"
module ufc_flow_test;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [4:0] addr = 5'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  logic rx_valid = 1'b0;
  logic [7:0] rx_char = 8'h00;
  logic [2:0] rx_err = 3'h0;
  logic tx_valid, tx_ready, cts_n, rts_n, int_req_n, rx_trig, tx_trig;
  logic [7:0] tx_word, last, d;
  logic stop = 1'b0;
  logic slow = 1'b0;
  int got, base;
  int error_cnt = 0;
  int n_compared = 0;
  always #10 ref_clk = ~ref_clk;
  ufc_flow ufc_flow_inst (.ref_clk(ref_clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .rx_valid(rx_valid), .rx_char(rx_char), .rx_err(rx_err), .tx_valid(tx_valid),
    .tx_word(tx_word), .tx_ready(tx_ready), .cts_n(cts_n), .rts_n(rts_n), .int_req_n(int_req_n),
    .rx_trig(rx_trig), .tx_trig(tx_trig));
  ufc_remote ufc_remote_inst (.ref_clk(ref_clk), .tx_valid(tx_valid), .tx_word(tx_word), .tx_ready(tx_ready),
    .stop(stop), .slow(slow), .cts_n(cts_n), .got(got), .last(last));
  task summarize();
    $display("mismatches %0d of %0d compares", error_cnt, n_compared);
    if (error_cnt == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input logic [7:0] g, input logic [7:0] e);
    n_compared++;
    if (g !== e)
    begin
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
      error_cnt++;
    end
  endtask
  task wreg(input logic [4:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask
  task rreg(input logic [4:0] a);
    @(posedge ref_clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task rx(input logic [7:0] c);
    @(posedge ref_clk);
    rx_valid <= 1'b1;
    rx_char <= c;
    @(posedge ref_clk);
    rx_valid <= 1'b0;
    repeat (2) @(posedge ref_clk);
  endtask
  // bounded wait for the remote to take a word
  task wait_got(input int n);
    int i;
    for (i = 0; i < 60 && got != n; i++)
      @(posedge ref_clk);
    if (got != n)
    begin
      $display("unexpected at %0t: got %h exp %h", $time, got, n);
      error_cnt++;
      summarize();
    end
  endtask
  task t_reset();
    chk({rts_n, int_req_n, rx_trig, tx_trig}, 8'h0d);
    rreg(`UFC_A_IIR);
    chk(d, `UFC_IIR_NONE);
    rreg(`UFC_A_LCR);
    chk(d, `UFC_LCR_RST);
    rreg(5'h1f);
    chk(d, 8'h00);
    rx(8'h41);
    chk(rx_trig, 8'h01);
    rreg(`UFC_A_DATA);
    chk(d, 8'h41);
  endtask
  task t_rts();
    int i;
    wreg(`UFC_A_TCR, 8'h12);
    wreg(`UFC_A_EFR, 8'h40);
    for (i = 0; i < 7; i++)
      rx(8'h30 + i[7:0]);
    chk(rts_n, 8'h00);
    rx(8'h37);
    chk(rts_n, 8'h01);
    for (i = 0; i < 4; i++)
      rreg(`UFC_A_DATA);
    repeat (2) @(posedge ref_clk);
    chk(rts_n, 8'h00);
    wreg(`UFC_A_FCR, 8'h02);
  endtask
  task t_pause();
    wreg(`UFC_A_PA, 8'h13);
    wreg(`UFC_A_RA, 8'h11);
    wreg(`UFC_A_IER, 8'h20);
    wreg(`UFC_A_EFR, 8'h02);
    base = got;
    rx(8'h13);
    chk(int_req_n, 8'h00);
    rreg(`UFC_A_RXLVL);
    chk(d, 8'h00);
    wreg(`UFC_A_DATA, 8'h5a);
    repeat (12) @(posedge ref_clk);
    chk(got - base, 8'h00);
    rreg(`UFC_A_IIR);
    chk(d, `UFC_IIR_XOFF);
    rx(8'h11);
    chk(int_req_n, 8'h01);
    wait_got(base + 1);
    chk(last, 8'h5a);
  endtask
  task t_cts();
    wreg(`UFC_A_EFR, 8'h80);
    stop <= 1'b1;
    slow <= 1'b1;
    base = got;
    wreg(`UFC_A_DATA, 8'h3c);
    repeat (12) @(posedge ref_clk);
    chk(got - base, 8'h00);
    stop <= 1'b0;
    wait_got(base + 1);
    chk(last, 8'h3c);
  endtask
  // halt level 8, resume level 4 still set by the rts scenario
  task t_xmit();
    int i;
    wreg(`UFC_A_PB, 8'h23);
    wreg(`UFC_A_RB, 8'h21);
    wreg(`UFC_A_EFR, 8'h0c);
    base = got;
    for (i = 0; i < 9; i++)
      rx(8'h40 + i[7:0]);
    wait_got(base + 1);
    chk(last, 8'h13);
    wait_got(base + 2);
    chk(last, 8'h23);
    for (i = 0; i < 5; i++)
      rreg(`UFC_A_DATA);
    wait_got(base + 3);
    chk(last, 8'h11);
    wait_got(base + 4);
    chk(last, 8'h21);
    wreg(`UFC_A_FCR, 8'h02);
  endtask
  task t_pair();
    wreg(`UFC_A_EFR, 8'h03);
    rx(8'h13);
    rx(8'h55);
    rx(8'h23);
    chk(int_req_n, 8'h01);
    rx(8'h13);
    rx(8'h23);
    chk(int_req_n, 8'h00);
    wreg(`UFC_A_MCR, 8'h20);
    rx(8'h77);
    chk(int_req_n, 8'h01);
    wreg(`UFC_A_EFR, 8'h20);
    rx(8'h23);
    chk(int_req_n, 8'h00);
    rreg(`UFC_A_IIR);
    chk(d, `UFC_IIR_XOFF);
    chk(int_req_n, 8'h01);
    // six characters are stored at this point
    wreg(`UFC_A_FCR, 8'h01);
    @(negedge ref_clk);
    chk(rx_trig, 8'h00);
    wreg(`UFC_A_TLR, 8'h10);
    @(negedge ref_clk);
    chk(rx_trig, 8'h01);
    wreg(`UFC_A_FCR, 8'h02);
    wreg(`UFC_A_MCR, 8'h00);
  endtask
  task t_short();
    wreg(`UFC_A_EFR, 8'h00);
    wreg(`UFC_A_LCR, 8'h00);
    base = got;
    wreg(`UFC_A_DATA, 8'hff);
    wait_got(base + 1);
    chk(last, 8'h1f);
  endtask
  initial
  begin
    repeat (5) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge ref_clk);
    t_reset();
    t_rts();
    t_pause();
    t_cts();
    t_xmit();
    t_pair();
    t_short();
    summarize();
  end
endmodule

// >>> testbench/ufc_remote.sv
// remote serial end model: serializer handshake and cts pin
`timescale 1ns/1ps
module ufc_remote
(
  // clock
  input wire logic ref_clk,
  // transmitter side
  input wire logic tx_valid,
  input wire logic [7:0] tx_word,
  output logic tx_ready,
  // modem pin and pacing
  input wire logic stop,
  input wire logic slow,
  output logic cts_n,
  // observation
  output int got,
  output logic [7:0] last
);
  initial
  begin
    tx_ready = 1'b0;
    got = 0;
    last = 8'h00;
  end
  // stop is raised between characters, well before any stop bit midpoint
  assign cts_n = stop;
  always @(posedge ref_clk)
  begin
    if (tx_valid && tx_ready)
    begin
      got <= got + 1;
      last <= tx_word;
    end
    // slow pacing lets a word wait a cycle before it is taken
    tx_ready <= slow ? ~tx_ready : 1'b1;
  end
endmodule
